//--- verification/drive_run_ctrl_tb.sv
// Self-checking bench for the run gating and ramp timing block
`timescale 1ns/10ps
module drive_run_ctrl_tb;
  import drive_run_pkg::*;
  // Short fine tick keeps ramps within a few tens of thousands of cycles
  localparam int FC = 20;
  logic clk, rstn, fault_trip, fault_reset, run_req, rev_req, both, fwd_in, sec_in;
  drive_cfg_t cfg;
  drive_status_t status;
  int mismatches, cmp_count;
  int cyc = 0;
  int ss_count = 0;
  drive_run_ctrl #(.FINE_CYCLES(FC)) drive_run_ctrl_i (.clk(clk), .rstn(rstn), .cfg(cfg),
    .forward_run_input(fwd_in), .second_run_input(sec_in), .fault_trip(fault_trip),
    .fault_reset(fault_reset), .status(status));
  term_block term_block_i (.mode(cfg.command_source), .run_req(run_req), .rev_req(rev_req),
    .both(both), .forward_run_input(fwd_in), .second_run_input(sec_in));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (status.speed_search_start === 1'b1) ss_count <= ss_count + 1;
    // Ceiling covers the long coarse ramp, two fine ramps, the restart delay and gating runs
    if (cyc == 80000) begin
      mismatches++;
      close_out();
    end
  end
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic cyc_n(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic wait_on(input logic exp, input int n);
    for (int i = 0; i < n && status.output_on !== exp; i++) @(negedge clk);
  endtask
  task automatic close_out();
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic t_powerup(input logic auto_on);
    int ss0;
    cfg.power_on_run_enable = auto_on;
    cfg.speed_search_options = auto_on ? 8'h10 : 8'h00;
    run_req = 1'b1;
    ss0 = ss_count;
    rstn = 1'b0;
    cyc_n(12);
    rstn = 1'b1;
    wait_on(1'b1, 20);
    chk("powerup on", status.output_on, auto_on);
    // The search pulse is only counted at the edge after it is launched
    cyc_n(1);
    chk("powerup search", 16'(ss_count - ss0), 16'(auto_on));
    run_req = 1'b0;
    cyc_n(2);
    run_req = 1'b1;
    wait_on(1'b1, 8);
    chk("rearmed on", status.output_on, 1'b1);
    chk("fwd dir", status.direction, DIR_FWD);
    run_req = 1'b0;
    wait_on(1'b0, 10);
  endtask
  task automatic t_lock(input logic [2:0] src, input logic [1:0] lock, input logic dir);
    cfg.command_source = src;
    cfg.direction_lock = lock;
    rev_req = dir;
    run_req = 1'b1;
    cyc_n(20);
    chk("locked off", status.output_on, 1'b0);
    // Open direction requested, but the select turns it back into the locked one
    rev_req = !dir;
    cfg.rotation_direction_select = 1'b1;
    cyc_n(4);
    chk("select into lock", status.output_on, 1'b0);
    cfg.rotation_direction_select = 1'b0;
    wait_on(1'b1, 8);
    chk("open dir on", status.output_on, 1'b1);
    chk("open dir", status.direction, !dir);
    run_req = 1'b0;
    wait_on(1'b0, 10);
    rev_req = dir;
    run_req = 1'b1;
    cyc_n(4);
    chk("relocked off", status.output_on, 1'b0);
    cfg.direction_lock = LOCK_NONE;
    wait_on(1'b1, 8);
    chk("unlocked on", status.output_on, 1'b1);
    chk("unlocked dir", status.direction, dir);
    run_req = 1'b0;
    wait_on(1'b0, 10);
  endtask
  task automatic t_trip();
    int ss0;
    cfg.command_source = SRC_TERM_FWD_REV;
    cfg.trip_reset_restart_enable = 1'b1;
    cfg.speed_search_options = 8'h04;
    rev_req = 1'b0;
    run_req = 1'b1;
    wait_on(1'b1, 8);
    fault_trip = 1'b1;
    cyc_n(1);
    fault_trip = 1'b0;
    cyc_n(2);
    chk("trip cut", status.output_on, 1'b0);
    chk("tripped", status.tripped, 1'b1);
    ss0 = ss_count;
    fault_reset = 1'b1;
    cyc_n(1);
    fault_reset = 1'b0;
    wait_on(1'b1, 8);
    chk("restart on", status.output_on, 1'b1);
    cyc_n(1);
    chk("restart search", 16'(ss_count - ss0), 16'h0001);
    both = 1'b1;
    wait_on(1'b0, 10);
    chk("both stop", status.output_on, 1'b0);
    both = 1'b0;
    run_req = 1'b0;
    cyc_n(4);
  endtask
  task automatic t_auto();
    int n;
    int exp;
    n = 0;
    // Delay counts coarse units, each ten fine ticks of FC cycles
    exp = int'(RESTART_DELAY_RESET) * int'(FINE_PER_COARSE) * FC;
    cfg.trip_reset_restart_enable = 1'b0;
    cfg.auto_restart_count = 4'h1;
    run_req = 1'b1;
    wait_on(1'b1, 8);
    fault_trip = 1'b1;
    cyc_n(1);
    fault_trip = 1'b0;
    cyc_n(2);
    chk("auto attempts", status.restart_attempts, 16'h0001);
    chk("auto waiting", status.output_on, 1'b0);
    while (status.output_on !== 1'b1 && n < 4000) begin
      @(negedge clk);
      n++;
    end
    // The coarse timebase runs free, so the first count lands anywhere within one unit
    chk("auto delay", 16'(n > exp - 12 * FC && n <= exp + 2 * FC), 16'h0001);
    run_req = 1'b0;
    wait_on(1'b0, 10);
    chk("auto cleared", status.restart_attempts, 16'h0000);
    cfg.auto_restart_count = 4'h0;
  endtask
  task automatic t_ramp(input logic unit, input logic rf);
    int n;
    int exp;
    int step;
    n = 0;
    step = FC * (unit ? 10 : 1);
    exp = 100 * step;
    cfg.ramp_time_unit = unit;
    cfg.ramp_reference_select = rf;
    // Doubled top frequency: a top-referenced ramp would end in half the time
    cfg.top_frequency = rf ? 16'h04b0 : 16'h0258;
    cfg.target_frequency = 16'h0258;
    run_req = 1'b1;
    wait_on(1'b1, 8);
    while (status.output_frequency !== 16'h0258 && n < 25000) begin
      @(negedge clk);
      n++;
    end
    // The timebase runs free, so the first step lands anywhere within one unit
    chk("accel time", 16'(n > exp - step - 2 * FC && n < exp + step), 16'h0001);
    n = 0;
    cfg.target_frequency = 16'h0000;
    run_req = 1'b0;
    while (status.output_frequency !== 16'h0000 && n < 25000) begin
      @(negedge clk);
      n++;
    end
    chk("decel time", 16'(n > exp - step - 2 * FC && n < exp + step), 16'h0001);
    wait_on(1'b0, 10);
    chk("ramp stop", status.output_frequency, 16'h0000);
  endtask
  initial begin
    mismatches = 0;
    cmp_count = 0;
    rstn = 1'b0;
    {fault_trip, fault_reset, run_req, rev_req, both} = '0;
    cfg = '0;
    cfg.command_source = SRC_TERM_FWD_REV;
    cfg.auto_restart_delay = RESTART_DELAY_RESET;
    cfg.accel_time = 16'h0064;
    cfg.decel_time = 16'h0064;
    cfg.top_frequency = 16'h0258;
    t_powerup(1'b1);
    t_powerup(1'b0);
    t_lock(SRC_TERM_FWD_REV, LOCK_FWD, DIR_FWD);
    t_lock(SRC_TERM_RUN_DIR, LOCK_REV, DIR_REV);
    t_trip();
    t_auto();
    t_ramp(UNIT_FINE, REF_TOP_FREQ);
    t_ramp(UNIT_COARSE, REF_TOP_FREQ);
    t_ramp(UNIT_FINE, REF_DELTA_FREQ);
    close_out();
  end
endmodule
bind drive_run_ctrl drive_run_sva drive_run_sva_i (.clk(clk), .rstn(rstn), .cfg(cfg),
  .forward_run_input(forward_run_input), .second_run_input(second_run_input),
  .fault_trip(fault_trip), .fault_reset(fault_reset), .status(status));

//--- verification/drive_run_sva.sv
// Port-level property checker for the run gating block
`timescale 1ns/10ps
module drive_run_sva
  import drive_run_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire drive_cfg_t cfg,
  input wire logic forward_run_input,
  input wire logic second_run_input,
  input wire logic fault_trip,
  input wire logic fault_reset,
  input wire drive_status_t status
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  property p_trip_cut; fault_trip |=> !status.output_on; endproperty
  a_trip_cut: assert property (p_trip_cut) else $error("output on after trip");
  property p_trip_free; $rose(status.tripped) |=> status.output_frequency == 16'h0000;
  endproperty
  a_trip_free: assert property (p_trip_free) else $error("frequency kept after trip");
  property p_lock_fwd;
    $rose(status.output_on) && $past(cfg.direction_lock) == LOCK_FWD |-> status.direction;
  endproperty
  a_lock_fwd: assert property (p_lock_fwd) else $error("forward start while locked");
  property p_lock_rev;
    $rose(status.output_on) && $past(cfg.direction_lock) == LOCK_REV |-> !status.direction;
  endproperty
  a_lock_rev: assert property (p_lock_rev) else $error("reverse start while locked");
  property p_mode1;
    $rose(status.output_on) && $past(cfg.command_source) == SRC_TERM_FWD_REV
      |-> $past(forward_run_input) != $past(second_run_input);
  endproperty
  a_mode1: assert property (p_mode1) else $error("start on stop pattern");
  property p_mode2;
    $rose(status.output_on) && $past(cfg.command_source) == SRC_TERM_RUN_DIR
      |-> $past(forward_run_input)
      && status.direction == ($past(second_run_input) ^ $past(cfg.rotation_direction_select));
  endproperty
  a_mode2: assert property (p_mode2) else $error("run/dir start wrong");
  property p_src;
    $rose(status.output_on) |-> $past(cfg.command_source) inside {3'h1, 3'h2};
  endproperty
  a_src: assert property (p_src) else $error("start without terminal source");
  property p_no_search;
    $rose(status.output_on) && $past(cfg.speed_search_options[2]) == 1'b0
      && $past(cfg.speed_search_options[4]) == 1'b0 |-> !status.speed_search_start;
  endproperty
  a_no_search: assert property (p_no_search) else $error("unrequested search");
endmodule

//--- verification/term_block.sv
// Terminal block model: turns run and direction requests into input levels
`timescale 1ns/10ps
module term_block
  import drive_run_pkg::*;
(
  input wire logic [2:0] mode,
  input wire logic run_req,
  input wire logic rev_req,
  input wire logic both,
  output logic forward_run_input,
  output logic second_run_input
);
  always_comb begin
    if (mode == SRC_TERM_RUN_DIR) begin
      forward_run_input = run_req;
      second_run_input = rev_req;
    end else begin
      forward_run_input = (run_req & !rev_req) | both;
      second_run_input = (run_req & rev_req) | both;
    end
  end
endmodule

//--- verilog/drive_run_ctrl.sv
// Run command gating, power-up autorun, trip restart and ramp time base of the drive
//
// Notes on behaviour
// - Lock code: 0 none, 1 forward, 2 reverse
// - Direction select cannot turn into locked direction
// - Autorun starts at power-up if terminal run on
// - Without autorun, run needs off then on
// - Options bit 4: speed search on autorun start
// - No speed search: plain start, accelerate from zero
// - Fault trip cuts output at once
// - Options bit 2: speed search on restart
// - Restart enabled: run resumes on fault reset
// - Restart count 0-10, delay 0-60 s
// - Ramp reference: 0 top frequency, 1 delta
// - Ramp time spans zero to top frequency with reference 0
// - Ramp times 0.0 to 600.0 s, defaults 5/10
// - Time unit: 0 gives 0.01 s, 1 gives 0.1 s
// - Unit change keeps count, rescales time
// - Mode 1: fwd/rev inputs, both or none stop
// - Mode 2: run input plus direction input
`timescale 1ns/10ps
module drive_run_ctrl
  import drive_run_pkg::*;
#(
  parameter int FINE_CYCLES = FINE_STEP_CYCLES
)
(
  input wire logic clk,
  input wire logic rstn,
  input wire drive_cfg_t cfg,
  input wire logic forward_run_input,
  input wire logic second_run_input,
  input wire logic fault_trip,
  input wire logic fault_reset,
  output drive_status_t status
);

  typedef struct packed {
    run_state_t state;
    logic powered;
    logic armed;
    logic autorun_pending;
    logic dir;
    logic search;
    logic [3:0] attempts;
    logic [9:0] delay_cnt;
    logic [31:0] fine_cnt;
    logic [3:0] coarse_cnt;
    logic tick_fine;
    logic tick_coarse;
  } ctl_t;

  ctl_t ctl_reg;
  ctl_t ctl_next;
  logic [FREQ_W-1:0] ramp_freq;
  logic [FREQ_W-1:0] ramp_target;
  logic req_on;
  logic req_dir;
  logic locked;
  logic req_ok;
  logic terminal_mode;
  logic [3:0] restart_limit;
  logic [9:0] delay_limit;

  always_comb begin
    logic raw_dir;
    terminal_mode = (cfg.command_source == SRC_TERM_FWD_REV) ||
                    (cfg.command_source == SRC_TERM_RUN_DIR);
    req_on = 1'b0;
    raw_dir = DIR_FWD;
    if (cfg.command_source == SRC_TERM_FWD_REV) begin
      req_on = forward_run_input ^ second_run_input;
      raw_dir = second_run_input ? DIR_REV : DIR_FWD;
    end else if (cfg.command_source == SRC_TERM_RUN_DIR) begin
      req_on = forward_run_input;
      raw_dir = second_run_input ? DIR_REV : DIR_FWD;
    end
    // Direction select reverses sense, but the lock check sees the final direction
    req_dir = raw_dir ^ cfg.rotation_direction_select;
    locked = req_on && (((cfg.direction_lock == LOCK_FWD) && (req_dir == DIR_FWD)) ||
                        ((cfg.direction_lock == LOCK_REV) && (req_dir == DIR_REV)));
    req_ok = req_on && !locked && ctl_reg.armed;
    // Settings beyond range are clamped to the top of range
    restart_limit = (cfg.auto_restart_count > RESTART_COUNT_MAX) ? RESTART_COUNT_MAX :
                    cfg.auto_restart_count;
    delay_limit = (cfg.auto_restart_delay > RESTART_DELAY_MAX) ? RESTART_DELAY_MAX :
                  cfg.auto_restart_delay;
  end

  always_comb begin
    ctl_next = ctl_reg;
    ctl_next.tick_fine = 1'b0;
    ctl_next.tick_coarse = 1'b0;
    ctl_next.search = 1'b0;
    if (ctl_reg.fine_cnt >= 32'(FINE_CYCLES - 1)) begin
      ctl_next.fine_cnt = 32'h0000_0000;
      ctl_next.tick_fine = 1'b1;
      if (ctl_reg.coarse_cnt >= FINE_PER_COARSE - 4'h1) begin
        ctl_next.coarse_cnt = 4'h0;
        ctl_next.tick_coarse = 1'b1;
      end else begin
        ctl_next.coarse_cnt = ctl_reg.coarse_cnt + 4'h1;
      end
    end else begin
      ctl_next.fine_cnt = ctl_reg.fine_cnt + 32'h0000_0001;
    end

    if (!ctl_reg.powered) begin
      // First cycle after reset decides whether a run already on may start
      ctl_next.powered = 1'b1;
      ctl_next.armed = cfg.power_on_run_enable && terminal_mode;
      ctl_next.autorun_pending = cfg.power_on_run_enable && terminal_mode;
    end else if (!req_on) begin
      ctl_next.armed = 1'b1;
      ctl_next.autorun_pending = 1'b0;
    end

    if (fault_trip && (ctl_reg.state != ST_TRIP)) begin
      ctl_next.state = ST_TRIP;
      ctl_next.armed = 1'b0;
      ctl_next.autorun_pending = 1'b0;
    end else begin
      unique case (ctl_reg.state)
        ST_IDLE: begin
          if (ctl_reg.powered && req_ok) begin
            ctl_next.state = ST_RUN;
            ctl_next.dir = req_dir;
            ctl_next.search = ctl_reg.autorun_pending &&
                              cfg.speed_search_options[SS_BIT_POWER_ON];
            ctl_next.autorun_pending = 1'b0;
          end
        end
        ST_RUN: begin
          // Reversal or stop waits for the ramp to reach zero first
          if (ramp_freq == '0 && ramp_target == '0) begin
            if (req_ok) begin
              ctl_next.dir = req_dir;
            end else begin
              ctl_next.state = ST_IDLE;
              ctl_next.attempts = 4'h0;
            end
          end
        end
        ST_TRIP: begin
          // A reset while the fault still stands must not bring the output back
          if (fault_reset && !fault_trip) begin
            if (cfg.trip_reset_restart_enable && req_on && !locked) begin
              ctl_next.state = ST_RUN;
              ctl_next.dir = req_dir;
              ctl_next.armed = 1'b1;
              ctl_next.search = cfg.speed_search_options[SS_BIT_RESTART];
            end else begin
              ctl_next.state = ST_IDLE;
            end
          end else if (!fault_trip && (ctl_reg.attempts < restart_limit)) begin
            ctl_next.state = ST_WAIT;
            ctl_next.delay_cnt = 10'h000;
            ctl_next.attempts = ctl_reg.attempts + 4'h1;
          end
        end
        ST_WAIT: begin
          if (ctl_reg.delay_cnt >= delay_limit) begin
            if (req_on && !locked) begin
              ctl_next.state = ST_RUN;
              ctl_next.dir = req_dir;
              ctl_next.armed = 1'b1;
              ctl_next.search = cfg.speed_search_options[SS_BIT_RESTART];
            end else begin
              ctl_next.state = ST_IDLE;
            end
          end else if (ctl_reg.tick_coarse) begin
            ctl_next.delay_cnt = ctl_reg.delay_cnt + 10'h001;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctl_reg <= '{state: ST_IDLE, default: '0};
    end else begin
      ctl_reg <= ctl_next;
    end
  end

  // Running toward target only while the request still matches the running direction
  assign ramp_target = (ctl_reg.state == ST_RUN && req_ok && req_dir == ctl_reg.dir) ?
                       cfg.target_frequency : '0;

  ramp_stepper u_ramp (
    .clk(clk),
    .rstn(rstn),
    // Stored counts stay as set; only the tick rate follows the unit
    .tick(cfg.ramp_time_unit == UNIT_COARSE ? ctl_reg.tick_coarse : ctl_reg.tick_fine),
    .hold_zero(ctl_reg.state != ST_RUN),
    .reference_select(cfg.ramp_reference_select),
    .top_frequency(cfg.top_frequency),
    .accel_time(cfg.accel_time > RAMP_TIME_MAX ? RAMP_TIME_MAX : cfg.accel_time),
    .decel_time(cfg.decel_time > RAMP_TIME_MAX ? RAMP_TIME_MAX : cfg.decel_time),
    .target(ramp_target),
    .freq(ramp_freq)
  );

  assign status.output_on = ctl_reg.state == ST_RUN;
  assign status.direction = ctl_reg.dir;
  assign status.speed_search_start = ctl_reg.search;
  assign status.tripped = ctl_reg.state == ST_TRIP;
  assign status.restart_attempts = ctl_reg.attempts;
  assign status.output_frequency = ramp_freq;

endmodule

//--- verilog/drive_run_pkg.sv
// Shared constants and carrier types for the drive run gating and ramp timing block
package drive_run_pkg;

  localparam int CLK_HZ = 25_000_000;
  // Finest ramp time step in milliseconds and its cycle count
  localparam int FINE_STEP_MS = 10;
  localparam int FINE_STEP_CYCLES = CLK_HZ / 1000 * FINE_STEP_MS;
  // Coarse step (0.1 s) is ten fine steps; restart delay also counts in 0.1 s
  localparam logic [3:0] FINE_PER_COARSE = 4'ha;

  localparam int FREQ_W = 16;
  localparam int TIME_W = 16;

  localparam logic [2:0] SRC_KEYPAD = 3'h0;
  localparam logic [2:0] SRC_TERM_FWD_REV = 3'h1;
  localparam logic [2:0] SRC_TERM_RUN_DIR = 3'h2;

  localparam logic [1:0] LOCK_NONE = 2'h0;
  localparam logic [1:0] LOCK_FWD = 2'h1;
  localparam logic [1:0] LOCK_REV = 2'h2;

  localparam int SS_BIT_RESTART = 2;
  localparam int SS_BIT_POWER_ON = 4;

  localparam logic DIR_FWD = 1'b0;
  localparam logic DIR_REV = 1'b1;

  localparam logic REF_TOP_FREQ = 1'b0;
  localparam logic REF_DELTA_FREQ = 1'b1;
  localparam logic UNIT_FINE = 1'b0;
  localparam logic UNIT_COARSE = 1'b1;

  localparam logic [3:0] RESTART_COUNT_MAX = 4'ha;
  localparam logic [3:0] RESTART_COUNT_RESET = 4'h0;
  localparam logic [9:0] RESTART_DELAY_MAX = 10'h0258;
  localparam logic [9:0] RESTART_DELAY_RESET = 10'h000a;
  localparam logic [TIME_W-1:0] ACCEL_RESET = 16'h0032;
  localparam logic [TIME_W-1:0] DECEL_RESET = 16'h0064;
  localparam logic [TIME_W-1:0] RAMP_TIME_MAX = 16'h1770;
  localparam logic [FREQ_W-1:0] TOP_FREQ_RESET = 16'h1770;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_RUN = 4'b0010,
    ST_TRIP = 4'b0100,
    ST_WAIT = 4'b1000
  } run_state_t;

  typedef struct packed {
    logic [2:0] command_source;
    logic [1:0] direction_lock;
    logic rotation_direction_select;
    logic power_on_run_enable;
    logic [7:0] speed_search_options;
    logic trip_reset_restart_enable;
    logic [3:0] auto_restart_count;
    logic [9:0] auto_restart_delay;
    logic ramp_reference_select;
    logic ramp_time_unit;
    logic [TIME_W-1:0] accel_time;
    logic [TIME_W-1:0] decel_time;
    logic [FREQ_W-1:0] top_frequency;
    logic [FREQ_W-1:0] target_frequency;
  } drive_cfg_t;

  typedef struct packed {
    logic output_on;
    logic direction;
    logic speed_search_start;
    logic tripped;
    logic [3:0] restart_attempts;
    logic [FREQ_W-1:0] output_frequency;
  } drive_status_t;

endpackage

//--- verilog/ramp_stepper.sv
// Frequency ramp generator: steps output frequency toward a target at a set time rate
`timescale 1ns/10ps
module ramp_stepper
  import drive_run_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic tick,
  input wire logic hold_zero,
  input wire logic reference_select,
  input wire logic [FREQ_W-1:0] top_frequency,
  input wire logic [TIME_W-1:0] accel_time,
  input wire logic [TIME_W-1:0] decel_time,
  input wire logic [FREQ_W-1:0] target,
  output logic [FREQ_W-1:0] freq
);

  typedef struct packed {
    logic [FREQ_W-1:0] freq;
    logic [31:0] acc;
    logic [FREQ_W-1:0] span;
    logic [FREQ_W-1:0] last_target;
  } ramp_t;

  ramp_t ramp_reg;
  ramp_t ramp_next;

  always_comb begin
    logic up;
    logic [TIME_W-1:0] ramp_time;
    logic [31:0] sum;
    up = target > ramp_reg.freq;
    ramp_time = up ? accel_time : decel_time;
    sum = ramp_reg.acc + (tick ? 32'(ramp_reg.span) : 32'h0000_0000);
    ramp_next = ramp_reg;
    if (hold_zero) begin
      // Output cut: frequency drops to zero at once, no ramp
      ramp_next = '0;
    end else if (target != ramp_reg.last_target) begin
      ramp_next.last_target = target;
      ramp_next.acc = 32'h0000_0000;
      if (reference_select == REF_DELTA_FREQ) begin
        ramp_next.span = up ? target - ramp_reg.freq : ramp_reg.freq - target;
      end else begin
        // Full 0 to top frequency takes exactly the set time
        ramp_next.span = top_frequency;
      end
    end else if (ramp_reg.freq == target) begin
      ramp_next.acc = 32'h0000_0000;
    end else if (ramp_time == '0) begin
      ramp_next.freq = target;
    end else begin
      // One frequency unit per clock at most; ticks are far apart so this never lags
      if (sum >= 32'(ramp_time)) begin
        ramp_next.freq = up ? ramp_reg.freq + 1'b1 : ramp_reg.freq - 1'b1;
        sum = sum - 32'(ramp_time);
      end
      ramp_next.acc = sum;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ramp_reg <= '0;
    end else begin
      ramp_reg <= ramp_next;
    end
  end

  assign freq = ramp_reg.freq;

endmodule
